// ==== cell_adc_trim_coeff_bank.sv ====
// APB slave that holds and presents the channel-one ADC trim coefficient bytes.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none

module cell_adc_trim_coeff_bank (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_N,
    // APB request from the host.
    input wire trim_bank_pkg::apb_req_s APB_REQ,
    // APB answer to the host.
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Load port from trim storage.
    input wire logic TRIM_LOAD,
    input wire trim_bank_pkg::trim_coeff_s TRIM_VALUE,
    // Coefficients and status toward the ADC correction logic.
    output trim_bank_pkg::trim_coeff_s COEFF_OUT,
    output logic TRIM_LOADED
);

    // Current state of the APB slave.
    trim_bank_pkg::apb_state_e state_r;
    // Next state of the APB slave.
    trim_bank_pkg::apb_state_e state_nxt;
    // Held coefficient set.
    trim_bank_pkg::trim_coeff_s coeff_r;
    // Set once a coefficient set has been taken from trim storage.
    logic loaded_r;
    // When set, trim storage loads are refused.
    logic freeze_r;
    // Registered answer signals.
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    // Index and alignment of the current request.
    logic [7:0] req_idx;
    logic req_aligned;

    // Pick the index out of the byte address.
    assign req_idx = APB_REQ.paddr[trim_bank_pkg::IDX_MSB:trim_bank_pkg::IDX_LSB];
    // Only whole aligned words inside the decoded window are mapped.
    assign req_aligned = (APB_REQ.paddr[1:0] == 2'h0) && (APB_REQ.paddr[11:10] == 2'h0);

    // Tells whether an index falls on one of the trim bytes.
    function automatic logic is_trim_idx(input logic [7:0] idx);
        is_trim_idx = (idx >= trim_bank_pkg::IDX_GAIN_TC3_LOW) &&
                      (idx <= trim_bank_pkg::IDX_OFS_TC1_HIGH_TC2_LOW);
    endfunction

    // Packs the coefficient slices into the byte seen at one index.
    function automatic logic [7:0] trim_byte(input logic [7:0] idx,
                                             input trim_bank_pkg::trim_coeff_s c);
        logic [7:0] b;
        b = trim_bank_pkg::TRIM_BYTE_RESET;
        if (idx == trim_bank_pkg::IDX_GAIN_TC3_LOW) begin
            b = {c.gain_third_order_coeff[4:0], c.gain_tc2_top};
        end else if (idx == trim_bank_pkg::IDX_GAIN_TC3_HIGH) begin
            b = {1'b0, c.gain_third_order_coeff[11:5]};
        end else if (idx == trim_bank_pkg::IDX_GAIN_TC4_LOW) begin
            b = c.gain_fourth_order_coeff[7:0];
        end else if (idx == trim_bank_pkg::IDX_GAIN_TC4_HIGH_OFS_TC0_LOW) begin
            b = {c.offset_zero_order_coeff[3:0], c.gain_fourth_order_coeff[11:8]};
        end else if (idx == trim_bank_pkg::IDX_OFS_TC0_MID) begin
            b = c.offset_zero_order_coeff[11:4];
        end else if (idx == trim_bank_pkg::IDX_OFS_TC0_TOP_TC1_LOW) begin
            b = {c.offset_first_order_coeff[5:0], c.offset_zero_order_coeff[13:12]};
        end else if (idx == trim_bank_pkg::IDX_OFS_TC1_HIGH_TC2_LOW) begin
            b = {c.offset_second_order_coeff, c.offset_first_order_coeff[11:6]};
        end
        trim_byte = b;
    endfunction

    // Next-state logic: setup leads to one wait cycle, then one answer cycle.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            // A setup cycle moves the slave into its wait cycle.
            trim_bank_pkg::ST_IDLE: begin
                if (APB_REQ.psel && !APB_REQ.penable) begin
                    state_nxt = trim_bank_pkg::ST_WAIT;
                end
            end
            // The access phase is answered one cycle later.
            trim_bank_pkg::ST_WAIT: begin
                if (APB_REQ.psel && APB_REQ.penable) begin
                    state_nxt = trim_bank_pkg::ST_RESP;
                end else begin
                    state_nxt = trim_bank_pkg::ST_IDLE;
                end
            end
            // The transfer completes on this edge.
            trim_bank_pkg::ST_RESP: begin
                state_nxt = trim_bank_pkg::ST_IDLE;
            end
            // Any stray code falls back to idle.
            default: begin
                state_nxt = trim_bank_pkg::ST_IDLE;
            end
        endcase
    end

    // State register of the APB slave.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= trim_bank_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Answer registers: data and error are prepared in the wait cycle.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_r <= trim_bank_pkg::PRDATA_RESET;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (state_r == trim_bank_pkg::ST_WAIT && APB_REQ.psel && APB_REQ.penable) begin
            pready_r <= 1'b1;
            prdata_r <= trim_bank_pkg::PRDATA_RESET;
            pslverr_r <= 1'b0;
            // Reads of the trim bytes return the packed slice.
            if (req_aligned && is_trim_idx(req_idx)) begin
                prdata_r <= {24'h00_0000, trim_byte(req_idx, coeff_r)};
                pslverr_r <= APB_REQ.pwrite;
            // Control word reads show the freeze and loaded state.
            end else if (req_aligned && req_idx == trim_bank_pkg::IDX_BANK_CTRL) begin
                prdata_r[trim_bank_pkg::CTRL_FREEZE_BIT] <= freeze_r;
                prdata_r[trim_bank_pkg::CTRL_LOADED_BIT] <= loaded_r;
            // Unmapped addresses read zero and flag an error.
            end else begin
                pslverr_r <= 1'b1;
            end
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= trim_bank_pkg::PRDATA_RESET;
        end
    end

    // Freeze bit: the only software-writable state, written at completion.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            freeze_r <= 1'b0;
        end else if (state_r == trim_bank_pkg::ST_RESP && APB_REQ.psel && APB_REQ.penable &&
                     APB_REQ.pwrite && req_aligned && req_idx == trim_bank_pkg::IDX_BANK_CTRL) begin
            freeze_r <= APB_REQ.pwdata[trim_bank_pkg::CTRL_FREEZE_BIT];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            coeff_r <= '0;
        end else if (TRIM_LOAD && !freeze_r) begin
            coeff_r <= TRIM_VALUE;
        end
    end

    // Loaded flag is sticky until reset; nothing clears it.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            loaded_r <= 1'b0;
        end else if (TRIM_LOAD && !freeze_r) begin
            loaded_r <= 1'b1;
        end
    end

    // Every output comes straight from a flip-flop.
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign COEFF_OUT = coeff_r;
    assign TRIM_LOADED = loaded_r;

    // Checks on the slave; all run on CLK and are off during reset.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // Access cycle of an aligned read that the slave is about to answer.
    sequence s_read_at(logic [7:0] idx);
        state_r == trim_bank_pkg::ST_WAIT && APB_REQ.psel && APB_REQ.penable &&
        !APB_REQ.pwrite && req_aligned && req_idx == idx;
    endsequence

    // Setup followed by access, the opening of every transfer.
    sequence s_transfer_open;
        (state_r == trim_bank_pkg::ST_IDLE && APB_REQ.psel && !APB_REQ.penable) ##1
        (APB_REQ.psel && APB_REQ.penable);
    endsequence

    // Each transfer gets one wait cycle, one ready cycle, then ready drops.
    property p_answer_timing;
        s_transfer_open |-> !PREADY ##1 PREADY ##1 !PREADY;
    endproperty
    a_answer_timing: assert property (p_answer_timing) else $error("APB answer timing wrong");

    property p_tc3_low;
        s_read_at(trim_bank_pkg::IDX_GAIN_TC3_LOW) |=>
            PREADY && PRDATA[31:8] == 24'h0 &&
            PRDATA[7:3] == $past(coeff_r.gain_third_order_coeff[4:0]);
    endproperty
    a_tc3_low: assert property (p_tc3_low) else $error("Byte 0x56 slice wrong");

    property p_tc3_high;
        s_read_at(trim_bank_pkg::IDX_GAIN_TC3_HIGH) |=>
            PREADY && !PRDATA[7] && PRDATA[6:0] == $past(coeff_r.gain_third_order_coeff[11:5]);
    endproperty
    a_tc3_high: assert property (p_tc3_high) else $error("Byte 0x57 slice wrong");

    property p_tc4_low;
        s_read_at(trim_bank_pkg::IDX_GAIN_TC4_LOW) |=>
            PREADY && PRDATA == {24'h0, $past(coeff_r.gain_fourth_order_coeff[7:0])};
    endproperty
    a_tc4_low: assert property (p_tc4_low) else $error("Byte 0x58 slice wrong");

    property p_tc4_high;
        s_read_at(trim_bank_pkg::IDX_GAIN_TC4_HIGH_OFS_TC0_LOW) |=>
            PRDATA[3:0] == $past(coeff_r.gain_fourth_order_coeff[11:8]);
    endproperty
    a_tc4_high: assert property (p_tc4_high) else $error("Byte 0x59 low nibble wrong");

    property p_tc0_low;
        s_read_at(trim_bank_pkg::IDX_GAIN_TC4_HIGH_OFS_TC0_LOW) |=>
            PRDATA[7:4] == $past(coeff_r.offset_zero_order_coeff[3:0]);
    endproperty
    a_tc0_low: assert property (p_tc0_low) else $error("Byte 0x59 high nibble wrong");

    property p_tc0_mid;
        s_read_at(trim_bank_pkg::IDX_OFS_TC0_MID) |=>
            PRDATA[7:0] == $past(coeff_r.offset_zero_order_coeff[11:4]) && !PSLVERR;
    endproperty
    a_tc0_mid: assert property (p_tc0_mid) else $error("Byte 0x5A slice wrong");

    property p_tc0_top;
        s_read_at(trim_bank_pkg::IDX_OFS_TC0_TOP_TC1_LOW) |=>
            PRDATA[1:0] == $past(coeff_r.offset_zero_order_coeff[13:12]) &&
            PRDATA[7:2] == $past(coeff_r.offset_first_order_coeff[5:0]);
    endproperty
    a_tc0_top: assert property (p_tc0_top) else $error("Byte 0x5B slice wrong");

    property p_tc1_high;
        s_read_at(trim_bank_pkg::IDX_OFS_TC1_HIGH_TC2_LOW) |=>
            PRDATA[5:0] == $past(coeff_r.offset_first_order_coeff[11:6]);
    endproperty
    a_tc1_high: assert property (p_tc1_high) else $error("Byte 0x5C low bits wrong");

    property p_tc2_low;
        s_read_at(trim_bank_pkg::IDX_OFS_TC1_HIGH_TC2_LOW) |=>
            PRDATA[7:6] == $past(coeff_r.offset_second_order_coeff);
    endproperty
    a_tc2_low: assert property (p_tc2_low) else $error("Byte 0x5C high bits wrong");

    property p_write_ignored;
        (state_r == trim_bank_pkg::ST_RESP && APB_REQ.pwrite && !TRIM_LOAD) |=>
            $stable(coeff_r) && $stable(COEFF_OUT);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("Host write moved a coefficient");

    property p_write_error;
        (state_r == trim_bank_pkg::ST_WAIT && APB_REQ.psel && APB_REQ.penable &&
         APB_REQ.pwrite && req_aligned && is_trim_idx(req_idx)) |=> PREADY && PSLVERR;
    endproperty
    a_write_error: assert property (p_write_error)
        else $error("Trim byte write not refused");

    property p_freeze_holds;
        (freeze_r && TRIM_LOAD) |=> $stable(coeff_r);
    endproperty
    a_freeze_holds: assert property (p_freeze_holds)
        else $error("Load taken while frozen");

    // The answer stands for exactly one cycle, so a stale ready cannot end a later transfer.
    property p_ready_pulse;
        PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held past one cycle");

    // The error flag only rides along with ready.
    property p_err_with_ready;
        PSLVERR |-> PREADY;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("Error flag without ready");

    // Read data is zero outside the answer cycle.
    property p_data_idle;
        !PREADY |-> PRDATA == trim_bank_pkg::PRDATA_RESET;
    endproperty
    a_data_idle: assert property (p_data_idle) else $error("Read data outside answer");

    // Each word carries one byte; the upper bits of every answer read zero.
    property p_upper_zero;
        PREADY |-> PRDATA[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("Upper read bits not zero");

    // Misaligned or out-of-window access is answered with an error and zero data.
    property p_unmapped_error;
        (state_r == trim_bank_pkg::ST_WAIT && APB_REQ.psel && APB_REQ.penable &&
         !req_aligned) |=>
            PREADY && PSLVERR && PRDATA == trim_bank_pkg::PRDATA_RESET;
    endproperty
    a_unmapped_error: assert property (p_unmapped_error)
        else $error("Unmapped access accepted");

    // Control word reads report the freeze and loaded state without error.
    property p_ctrl_read;
        s_read_at(trim_bank_pkg::IDX_BANK_CTRL) |=>
            PREADY && !PSLVERR && PRDATA[31:2] == 30'h0000_0000 &&
            PRDATA[trim_bank_pkg::CTRL_FREEZE_BIT] == $past(freeze_r) &&
            PRDATA[trim_bank_pkg::CTRL_LOADED_BIT] == $past(loaded_r);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("Control word read wrong");

    // A completed control write takes the freeze bit from the write data.
    property p_freeze_write;
        (state_r == trim_bank_pkg::ST_RESP && APB_REQ.psel && APB_REQ.penable &&
         APB_REQ.pwrite && req_aligned && req_idx == trim_bank_pkg::IDX_BANK_CTRL) |=>
            freeze_r == $past(APB_REQ.pwdata[trim_bank_pkg::CTRL_FREEZE_BIT]);
    endproperty
    a_freeze_write: assert property (p_freeze_write) else $error("Freeze bit not written");

    property p_load_taken;
        (TRIM_LOAD && !freeze_r) |=> COEFF_OUT == $past(TRIM_VALUE) && TRIM_LOADED;
    endproperty
    a_load_taken: assert property (p_load_taken) else $error("Trim load not taken");

    property p_no_load_hold;
        !TRIM_LOAD |=> $stable(COEFF_OUT);
    endproperty
    a_no_load_hold: assert property (p_no_load_hold) else $error("Coefficients moved");

    property p_loaded_sticky;
        TRIM_LOADED |=> TRIM_LOADED;
    endproperty
    a_loaded_sticky: assert property (p_loaded_sticky) else $error("Loaded flag fell");

endmodule

`default_nettype wire

// ==== cell_adc_trim_coeff_bank_tb_top.sv ====
// Self-checking testbench for the cell ADC trim coefficient bank.
`timescale 1ns/100ps
`default_nettype none

// Compares an expected and a seen value and counts the result.
`define CHK(w, e, g) chk(w, 64'(e), 64'(g))

module cell_adc_trim_coeff_bank_tb_top;
    // Clock, reset and bus signals.
    logic clk;
    logic rst_n;
    trim_bank_pkg::apb_req_s req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Trim load port and coefficient outputs.
    logic trim_load;
    logic trim_loaded;
    trim_bank_pkg::trim_coeff_s trim_value;
    trim_bank_pkg::trim_coeff_s coeff_out;
    // Coefficients the bank should hold, and the generator state.
    trim_bank_pkg::trim_coeff_s model;
    trim_bank_pkg::trim_coeff_s v;
    logic [15:0] lfsr_r;
    logic [31:0] rd;
    logic er;
    int err_total;
    int samples_checked;
    // Addresses outside the bank: unmapped index, misaligned, high bits set.
    logic [11:0] dut_addr_tbl [3] = '{12'h104, 12'h15d, 12'h558};

    cell_adc_trim_coeff_bank dut_u (
        .CLK(clk), .RST_N(rst_n), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TRIM_LOAD(trim_load), .TRIM_VALUE(trim_value),
        .COEFF_OUT(coeff_out), .TRIM_LOADED(trim_loaded)
    );

    // The clock toggles every 25 ns, a full period of 50 ns.
    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Prints the counts and the verdict, then stops the run.
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Counts one comparison and reports a difference at once.
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        int n;
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= addr;
        req.pwdata <= wd;
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // A slave that never answers ends the run through the closing task.
        if (n >= 20) begin
            err_total++;
            $display("mismatch pready expected 1 seen %b", pready);
            test_done;
        end
        rdat = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // Next state of the 16-bit shift register generator.
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Draws a full coefficient set from the generator.
    task automatic rand_coeff(output trim_bank_pkg::trim_coeff_s c);
        logic [63:0] w;
        w = '0;
        repeat (4) begin
            lfsr_r = lfsr_next(lfsr_r);
            w = {w[47:0], lfsr_r};
        end
        c = w[54:0];
    endtask

    // Byte the bank should show at an index for a coefficient set.
    function automatic logic [7:0] byte_exp(input logic [7:0] idx,
                                            input trim_bank_pkg::trim_coeff_s c);
        case (idx)
            8'h56: return {c.gain_third_order_coeff[4:0], c.gain_tc2_top};
            8'h57: return {1'b0, c.gain_third_order_coeff[11:5]};
            8'h58: return c.gain_fourth_order_coeff[7:0];
            8'h59: return {c.offset_zero_order_coeff[3:0], c.gain_fourth_order_coeff[11:8]};
            8'h5a: return c.offset_zero_order_coeff[11:4];
            8'h5b: return {c.offset_first_order_coeff[5:0], c.offset_zero_order_coeff[13:12]};
            8'h5c: return {c.offset_second_order_coeff, c.offset_first_order_coeff[11:6]};
            default: return 8'h00;
        endcase
    endfunction

    // Reads every trim byte and compares it with the held set.
    task automatic read_bank;
        logic [31:0] exp_w;
        for (int i = 8'h56; i <= 8'h5c; i++) begin
            apb(1'b0, {2'b00, 8'(i), 2'b00}, 32'h0000_0000, rd, er);
            exp_w = {24'h00_0000, byte_exp(8'(i), model)};
            `CHK("trim byte", exp_w, rd);
            `CHK("read error", 1'b0, er); // reads accepted
        end
    endtask

    // Presents one set on the load port for a single cycle.
    task automatic load(input trim_bank_pkg::trim_coeff_s c);
        @(posedge clk);
        trim_load <= 1'b1;
        trim_value <= c;
        @(posedge clk);
        trim_load <= 1'b0;
        #1;
    endtask

    // Main sequence of tests.
    initial begin
        rst_n = 1'b0;
        trim_load = 1'b0;
        trim_value = '0;
        req = '0;
        model = '0;
        lfsr_r = 16'hc3ec;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("coeff at reset", 55'h0, coeff_out); // zero reset
        read_bank;
        apb(1'b0, 12'h100, 32'h0000_0000, rd, er);
        `CHK("ctrl at reset", 32'h0000_0000, rd); // zero reset
        $display("test reset done");
        // Corner sets first, then random sets.
        for (int k = 0; k < 8; k++) begin
            rand_coeff(v);
            if (k == 0) v = '1;
            if (k == 1) v = 55'h2a_aaaa_aaaa_aaaa;
            load(v);
            model = v;
            `CHK("coeff out", model, coeff_out); // loaded set
            `CHK("loaded flag", 1'b1, trim_loaded); // loaded status
            read_bank;
        end
        $display("test load done");
        // Host writes to trim bytes are refused and change nothing.
        for (int i = 8'h56; i <= 8'h5c; i++) begin
            rand_coeff(v);
            apb(1'b1, {2'b00, 8'(i), 2'b00}, v[31:0], rd, er);
            `CHK("write error", 1'b1, er); // read-only
        end
        read_bank;
        `CHK("coeff after writes", model, coeff_out); // writes ignored
        $display("test write done");
        // Unmapped, misaligned and out-of-range addresses.
        foreach (dut_addr_tbl[j]) begin
            apb(1'b0, dut_addr_tbl[j], 32'h0000_0000, rd, er);
            `CHK("unmapped error", 1'b1, er); // outside bank
            `CHK("unmapped data", 32'h0000_0000, rd); // outside bank
        end
        $display("test unmapped done");
        // Freeze blocks loads until it is cleared again.
        apb(1'b1, 12'h100, 32'h0000_0001, rd, er);
        apb(1'b0, 12'h100, 32'h0000_0000, rd, er);
        `CHK("ctrl frozen", 32'h0000_0003, rd); // freeze status
        rand_coeff(v);
        load(v);
        `CHK("coeff frozen", model, coeff_out); // load blocked
        read_bank;
        apb(1'b1, 12'h100, 32'h0000_0000, rd, er);
        load(v);
        model = v;
        `CHK("coeff thawed", model, coeff_out); // load resumes
        read_bank;
        $display("test freeze done");
        test_done;
    end

    // Watchdog cuts a hang short well after the tests should end.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        test_done;
    end
endmodule

`default_nettype wire

// ==== trim_bank_pkg.sv ====
// Constants, field layouts and carrier types for the cell ADC trim coefficient bank.
//
// Overview of operation
// - 0x57 bits 6:0 give gain third-order bits 11:5
// - 0x58 gives gain fourth-order bits 7:0
// - 0x59 low nibble gives gain fourth-order 11:8
// - 0x59 high nibble gives offset zero-order 3:0
// - 0x5A gives offset zero-order bits 11:4
// - 0x5B: offset zero-order 13:12, first-order 5:0
// - 0x5C bits 5:0 give offset first-order 11:6
// - 0x5C bits 7:6 give offset second-order 1:0
// - 0x56 bits 7:3 give gain third-order 4:0
package trim_bank_pkg;

    // Register indices as printed; the APB byte address is four times the index.
    localparam logic [7:0] IDX_GAIN_TC3_LOW = 8'h56;
    localparam logic [7:0] IDX_GAIN_TC3_HIGH = 8'h57;
    localparam logic [7:0] IDX_GAIN_TC4_LOW = 8'h58;
    localparam logic [7:0] IDX_GAIN_TC4_HIGH_OFS_TC0_LOW = 8'h59;
    localparam logic [7:0] IDX_OFS_TC0_MID = 8'h5a;
    localparam logic [7:0] IDX_OFS_TC0_TOP_TC1_LOW = 8'h5b;
    localparam logic [7:0] IDX_OFS_TC1_HIGH_TC2_LOW = 8'h5c;

    // Control and status word of the bank itself.
    localparam logic [7:0] IDX_BANK_CTRL = 8'h40;

    // Bit positions inside the control and status word.
    localparam int CTRL_FREEZE_BIT = 0;
    localparam int CTRL_LOADED_BIT = 1;

    // APB address layout: index above, word alignment below.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // Reset values of every byte and of the control word.
    localparam logic [7:0] TRIM_BYTE_RESET = 8'h00;
    localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

    // Widths of the packed coefficients.
    localparam int GAIN_TC2_TOP_W = 3;
    localparam int GAIN_TC3_W = 12;
    localparam int GAIN_TC4_W = 12;
    localparam int OFS_TC0_W = 14;
    localparam int OFS_TC1_W = 12;
    localparam int OFS_TC2_LOW_W = 2;

    // Coefficient set as delivered by trim storage and used by the ADC.
    typedef struct packed {
        logic [GAIN_TC2_TOP_W-1:0] gain_tc2_top;
        logic [GAIN_TC3_W-1:0] gain_third_order_coeff;
        logic [GAIN_TC4_W-1:0] gain_fourth_order_coeff;
        logic [OFS_TC0_W-1:0] offset_zero_order_coeff;
        logic [OFS_TC1_W-1:0] offset_first_order_coeff;
        logic [OFS_TC2_LOW_W-1:0] offset_second_order_coeff;
    } trim_coeff_s;

    // APB request signals that travel together.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_s;

    // One-hot states of the APB slave.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RESP = 3'b100
    } apb_state_e;

endpackage
